// File: verilog/jtap_cfg.svh
`ifndef JTAP_CFG_SVH
`define JTAP_CFG_SVH
// =====================================================
// Instruction register
`define JTAP_IR_LEN 3
`define JTAP_IR_CAPTURE 3'h1
`define JTAP_OP_EXTEST 3'h0
`define JTAP_OP_IDCODE 3'h1
`define JTAP_OP_SAMPLE_Z 3'h2
`define JTAP_OP_SAMPLE 3'h4
`define JTAP_OP_BYPASS 3'h7
// =====================================================
// Data registers
`define JTAP_ID_LEN 32
`define JTAP_ID_VALUE 32'h00000001
`define JTAP_BSR_LEN 109
`define JTAP_BSR_HIZ_BIT 108
`define JTAP_SYNC_STAGES 2
`endif

// File: verilog/jtap_pkg.sv
package jtap_pkg;
  typedef enum logic [3:0] {
    JTAP_TLR = 4'h0,
    JTAP_RTI = 4'h1,
    JTAP_SEL_DR = 4'h2,
    JTAP_CAP_DR = 4'h3,
    JTAP_SHIFT_DR = 4'h4,
    JTAP_EXIT1_DR = 4'h5,
    JTAP_PAUSE_DR = 4'h6,
    JTAP_EXIT2_DR = 4'h7,
    JTAP_UPD_DR = 4'h8,
    JTAP_SEL_IR = 4'h9,
    JTAP_CAP_IR = 4'ha,
    JTAP_SHIFT_IR = 4'hb,
    JTAP_EXIT1_IR = 4'hc,
    JTAP_PAUSE_IR = 4'hd,
    JTAP_EXIT2_IR = 4'he,
    JTAP_UPD_IR = 4'hf
  } jtap_state_t;
endpackage : jtap_pkg

// File: verilog/jtap_sync.sv
// =====================================================
// Two-flop level synchroniser, one chain per bit
module jtap_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule : jtap_sync

// File: verilog/jtap_tap.sv
`include "jtap_cfg.svh"
module jtap_tap
  import jtap_pkg::*;
#(
  parameter int BSR_LEN = `JTAP_BSR_LEN,
  parameter logic [`JTAP_ID_LEN-1:0] ID_VALUE = `JTAP_ID_VALUE // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_float,
  input wire logic tdi,
  input wire logic tdi_float,
  input wire logic [BSR_LEN-1:0] bnd_in,
  output logic tdo,
  output logic tdo_oe,
  output logic tap_in_reset,
  output logic q_bus_hiz
);
  // =====================================================
  // Controller next state
  function automatic jtap_state_t tap_next(input jtap_state_t s, input logic m);
    case (s)
      JTAP_TLR: tap_next = m ? JTAP_TLR : JTAP_RTI;
      JTAP_RTI: tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
      JTAP_SEL_DR: tap_next = m ? JTAP_SEL_IR : JTAP_CAP_DR;
      JTAP_CAP_DR: tap_next = m ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
      JTAP_SHIFT_DR: tap_next = m ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
      JTAP_EXIT1_DR: tap_next = m ? JTAP_UPD_DR : JTAP_PAUSE_DR;
      JTAP_PAUSE_DR: tap_next = m ? JTAP_EXIT2_DR : JTAP_PAUSE_DR;
      JTAP_EXIT2_DR: tap_next = m ? JTAP_UPD_DR : JTAP_SHIFT_DR;
      JTAP_UPD_DR: tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
      JTAP_SEL_IR: tap_next = m ? JTAP_TLR : JTAP_CAP_IR;
      JTAP_CAP_IR: tap_next = m ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
      JTAP_SHIFT_IR: tap_next = m ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
      JTAP_EXIT1_IR: tap_next = m ? JTAP_UPD_IR : JTAP_PAUSE_IR;
      JTAP_PAUSE_IR: tap_next = m ? JTAP_EXIT2_IR : JTAP_PAUSE_IR;
      JTAP_EXIT2_IR: tap_next = m ? JTAP_UPD_IR : JTAP_SHIFT_IR;
      JTAP_UPD_IR: tap_next = m ? JTAP_SEL_DR : JTAP_RTI;
      default: tap_next = JTAP_TLR;
    endcase
  endfunction : tap_next

  // =====================================================
  // Instruction decode
  function automatic logic op_is_bsr(input logic [`JTAP_IR_LEN-1:0] op);
    case (op)
      `JTAP_OP_EXTEST: op_is_bsr = 1'h1;
      `JTAP_OP_SAMPLE: op_is_bsr = 1'h1;
      `JTAP_OP_SAMPLE_Z: op_is_bsr = 1'h1;
      default: op_is_bsr = 1'h0;
    endcase
  endfunction : op_is_bsr

  // =====================================================
  // Crossings
  logic rst_tck;
  logic [BSR_LEN-1:0] bnd_tck;
  logic [1:0] stat_sys;
  // Reset reaches the controller only while the test clock runs
  jtap_sync #(.W(1)) u_rst_sync (
    .clk(tck),
    .d(srst),
    .q(rst_tck)
  );
  // Each pin of the ring is an independent level, so bitwise sync is enough
  jtap_sync #(.W(BSR_LEN)) u_bnd_sync (
    .clk(tck),
    .d(bnd_in),
    .q(bnd_tck)
  );

  // =====================================================
  // Pins and decode
  jtap_state_t state;
  jtap_state_t next_state;
  logic [`JTAP_IR_LEN-1:0] ir;
  logic [`JTAP_IR_LEN-1:0] ir_sh;
  logic bypass_sh;
  logic [`JTAP_ID_LEN-1:0] id_sh;
  logic [BSR_LEN-1:0] bsr_sh;
  logic [BSR_LEN-1:0] bsr_upd;
  logic tap_reset_tck;
  logic hiz_tck;

  wire tms_eff = tms_float | tms;
  wire tdi_eff = tdi_float | tdi;
  wire sel_id = (ir == `JTAP_OP_IDCODE);
  wire sel_bsr = op_is_bsr(ir);

  // =====================================================
  // State strobes
  wire st_tlr = (state == JTAP_TLR);
  wire st_sh_dr = (state == JTAP_SHIFT_DR);
  wire st_sh_ir = (state == JTAP_SHIFT_IR);
  wire tap_clr = rst_tck | st_tlr;
  wire in_shift = st_sh_dr | st_sh_ir;
  wire dr_bit = sel_id ? id_sh[0] : (sel_bsr ? bsr_sh[0] : bypass_sh);
  wire next_tdo = st_sh_ir ? ir_sh[0] : dr_bit;
  wire extest_hiz = (ir == `JTAP_OP_EXTEST) & ~bsr_upd[`JTAP_BSR_HIZ_BIT];
  wire next_hiz = (ir == `JTAP_OP_SAMPLE_Z) | extest_hiz;
  assign next_state = tap_next(state, tms_eff);

  // =====================================================
  // Controller, rising edge
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      state <= JTAP_TLR;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================
  // Instruction register
  always_ff @(posedge tck) begin
    if (tap_clr) begin
      ir <= `JTAP_OP_IDCODE;
      ir_sh <= `JTAP_IR_CAPTURE;
    end else begin
      case (state)
        JTAP_CAP_IR: begin
          ir_sh <= `JTAP_IR_CAPTURE;
        end
        JTAP_SHIFT_IR: begin
          ir_sh <= {tdi_eff, ir_sh[`JTAP_IR_LEN-1:1]};
        end
        JTAP_UPD_IR: begin
          ir <= ir_sh;
        end
        default: begin
          ir <= ir;
        end
      endcase
    end
  end

  // =====================================================
  // Data registers
  always_ff @(posedge tck) begin
    if (tap_clr) begin
      bypass_sh <= 1'h0;
      id_sh <= ID_VALUE;
      bsr_sh <= '0;
      bsr_upd <= '0;
    end else begin
      case (state)
        JTAP_CAP_DR: begin
          bypass_sh <= 1'h0;
          if (sel_id) begin
            id_sh <= ID_VALUE;
          end
          if (sel_bsr) begin
            bsr_sh <= bnd_tck;
          end
        end
        JTAP_SHIFT_DR: begin
          if (sel_id) begin
            id_sh <= {tdi_eff, id_sh[`JTAP_ID_LEN-1:1]};
          end else if (sel_bsr) begin
            bsr_sh <= {tdi_eff, bsr_sh[BSR_LEN-1:1]};
          end else begin
            bypass_sh <= tdi_eff;
          end
        end
        JTAP_UPD_DR: begin
          if (sel_bsr) begin
            bsr_upd <= bsr_sh;
          end
        end
        default: begin
          bypass_sh <= bypass_sh;
        end
      endcase
    end
  end

  // =====================================================
  // Serial output, falling edge
  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
      tap_reset_tck <= 1'h1;
      hiz_tck <= 1'h0;
    end else begin
      tdo <= next_tdo;
      tdo_oe <= in_shift;
      tap_reset_tck <= st_tlr;
      hiz_tck <= next_hiz;
    end
  end

  // =====================================================
  // Status back to the system clock
  jtap_sync #(.W(2)) u_stat_sync (
    .clk(clk_sys),
    .d({tap_reset_tck, hiz_tck}),
    .q(stat_sys)
  );
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tap_in_reset <= 1'h1;
      q_bus_hiz <= 1'h0;
    end else begin
      tap_in_reset <= stat_sys[1];
      q_bus_hiz <= stat_sys[0];
    end
  end
endmodule : jtap_tap

// File: testbench/jtap_tap_props.sv
// ====
// TAP port checks
module jtap_tap_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tms_float,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tap_in_reset,
  input wire logic q_bus_hiz
);
  logic m;
  logic oe_r;
  logic do_r;
  assign m = tms | tms_float;
  always_ff @(posedge tck) begin
    oe_r <= tdo_oe;
    do_r <= tdo;
  end
  chk_oe_fall_only: assert property (@(negedge tck) disable iff (srst) tdo_oe == oe_r)
    else $error("tdo_oe moved on rise");
  chk_tdo_fall_only: assert property (@(negedge tck) disable iff (srst) tdo == do_r)
    else $error("tdo moved on rise");
  chk_oe_enter_shift: assert property (@(posedge tck) disable iff (srst)
    $rose(tdo_oe) |-> !$past(m)) else $error("shift entered without tms low");
  chk_oe_leave_shift: assert property (@(posedge tck) disable iff (srst)
    $fell(tdo_oe) |-> $past(m)) else $error("shift left without tms high");
  chk_five_ones: assert property (@(posedge tck) disable iff (srst)
    m [*5] |=> !tdo_oe) else $error("no reset after five ones");
  chk_rst_flag: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> tap_in_reset) else $error("not in reset after srst");
  chk_rst_hiz: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> !q_bus_hiz) else $error("bus hiz after srst");
  chk_shift_flag: assert property (@(posedge clk_sys) disable iff (srst)
    tdo_oe |-> ##[0:6] !tap_in_reset) else $error("reset flag while shifting");
  cover property (@(posedge tck) $rose(tdo_oe));
  cover property (@(posedge tck) m [*5]);
  cover property (@(posedge clk_sys) $rose(q_bus_hiz));
endmodule : jtap_tap_chk
bind jtap_tap jtap_tap_chk u_chk (.clk_sys, .srst, .tck, .tms, .tms_float, .tdo, .tdo_oe,
  .tap_in_reset, .q_bus_hiz);

// File: testbench/jtap_host.sv
// ====
// Test host, one period per step
module jtap_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic s, input logic d, output logic o);
    tms = s;
    tdi = d;
    #3;
    o = tdo;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
    #4.5;
  endtask : step
endmodule : jtap_host

// File: testbench/tb.sv
`include "jtap_cfg.svh"
// ====
// Test bench
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic tms_float = 1'b0;
  logic tdi_float = 1'b0;
  logic [108:0] bnd_in = 109'h0;
  logic tck, tms, tdi, tdo, tdo_oe, tap_in_reset, q_bus_hiz, o;
  logic [2:0] cap;
  logic [127:0] sh;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  localparam logic [2:0] OPS [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
  localparam int LENS [6] = '{109, 32, 109, 109, 1, 1};
  localparam logic HIZ [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  jtap_tap u_jtap_tap (.clk_sys, .srst, .tck, .tms, .tms_float, .tdi, .tdi_float, .bnd_in,
    .tdo, .tdo_oe, .tap_in_reset, .q_bus_hiz);
  jtap_host u_jtap_host (.tck, .tms, .tdi, .tdo);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input int n, input logic [7:0] s);
    for (int i = 0; i < n; i++) u_jtap_host.step(s[i], 1'b0, o);
  endtask : go
  task automatic shift_ir(input logic [2:0] op);
    go(4, 8'h03);
    for (int i = 0; i < 3; i++) u_jtap_host.step(i == 2, op[i], cap[i]);
    go(2, 8'h01);
  endtask : shift_ir
  task automatic shift_dr(input int n);
    go(3, 8'h01);
    for (int i = 0; i < n; i++) u_jtap_host.step(i == n - 1, i == 0, sh[i]);
    go(2, 8'h01);
  endtask : shift_dr
  task automatic settle();
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    go(5, 8'h1f);
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    go(4, 8'h0f);
    settle();
    chk("in_reset", 1, tap_in_reset);
    chk("hiz", 0, q_bus_hiz);
    chk("oe", 0, tdo_oe);
    go(1, 8'h00);
    shift_dr(33);
    chk("idcode", `JTAP_ID_VALUE, sh[31:0]);
    for (int r = 0; r < 6; r++) begin
      shift_ir(OPS[r]);
      chk("ir_cap", 32'h1, {30'h0, cap[1:0]});
      settle();
      chk("hiz", HIZ[r], q_bus_hiz);
      shift_dr(LENS[r] + 1);
      chk("marker", 1, sh[LENS[r]]);
    end
    tdi_float <= 1'b1;
    shift_ir(3'h0);
    tdi_float <= 1'b0;
    settle();
    chk("float_tdi", 0, q_bus_hiz);
    tms_float <= 1'b1;
    go(5, 8'h00);
    tms_float <= 1'b0;
    settle();
    chk("float_tms", 1, tap_in_reset);
    go(1, 8'h00);
    shift_dr(33);
    chk("idcode", `JTAP_ID_VALUE, sh[31:0]);
    results();
  end
endmodule : tb
